// ==== design/nand_op_sequencer.sv ====
// operation timing and invalid-block bookkeeping for a serial nand array
// Function
// - page load without correction within 25 us
// - page load with correction within 60 us
// - ready within 7 us after continuous read
// - program, lock, mapping typ 250, max 700 us
// - reset recovery 5/10/500 us after select
// - register write effective within 50 ns
// - blocks zero to seven always valid
// - at least 1004 of 1024 blocks valid
// - bad blocks report non-FF marker bytes
`timescale 1ns/1ns
module nand_op_sequencer
  import nand_seq_pkg::*;
#(
  parameter logic [CNT_W-1:0] PAGE_LOAD_CORR_CNT = CNT_W'(PAGE_LOAD_CORR_CYCLES),
  parameter logic [CNT_W-1:0] PROGRAM_CNT        = CNT_W'(PAGE_PROGRAM_TYP_CYCLES),
  parameter logic [CNT_W-1:0] ERASE_CNT          = CNT_W'(ERASE_TYP_CYCLES),
  parameter logic [CNT_W-1:0] RESET_ERASE_CNT    = CNT_W'(RESET_ERASE_CYCLES),
  parameter logic [CNT_W-1:0] RESET_PROGRAM_CNT  = CNT_W'(RESET_PROGRAM_CYCLES),
  parameter logic [CNT_W-1:0] RESET_READ_CNT     = CNT_W'(RESET_READ_CYCLES)
) (
  // clock and reset
  input  wire logic               clk_in,
  input  wire logic               rst_n_in,
  // serial link pins
  input  wire logic               cs_n_in,
  input  wire logic               sck_in,
  // decoded commands, same clock
  input  wire logic               op_start_in,
  input  wire op_req_type         op_req_in,
  input  wire logic               reset_cmd_in,
  input  wire logic               cont_read_in,
  input  wire logic               reg_write_in,
  input  wire logic [7:0]         reg_data_in,
  // marker lookup
  input  wire logic               marker_req_in,
  input  wire logic [BLOCK_W-1:0] marker_block_in,
  output logic [7:0]              marker_out,
  output logic                    marker_valid_out,
  // status
  output status_type              status_out,
  output logic                    op_done_out,
  output logic [7:0]              config_out,
  output logic [BLOCK_W:0]        valid_blocks_out
);
  // ------------------------------------------------------------
  // local constants and checks
  // ------------------------------------------------------------
  localparam logic [CNT_W-1:0] LOAD_CNT   = CNT_W'(PAGE_LOAD_NO_CORR_CYCLES);
  localparam logic [CNT_W-1:0] STOP_CNT   = CNT_W'(CONT_READ_STOP_CYCLES);
  localparam logic [BLOCK_W:0] MAX_BAD    = (BLOCK_W+1)'(MAX_BAD_BLOCKS);
  localparam logic [BLOCK_W:0] ALL_BLOCKS = (BLOCK_W+1)'(TOTAL_BLOCKS);
  localparam logic [BLOCK_W-1:0] LAST_SAFE = BLOCK_W'(GUARANTEED_LAST_BLOCK);

  if (PROGRAM_CNT == 0 || PROGRAM_CNT > CNT_W'(PAGE_PROGRAM_MAX_CYCLES)
      || ERASE_CNT == 0 || ERASE_CNT > CNT_W'(ERASE_MAX_CYCLES)
      || PAGE_LOAD_CORR_CNT == 0 || PAGE_LOAD_CORR_CNT > CNT_W'(PAGE_LOAD_CORR_CYCLES)
      || RESET_READ_CNT == 0 || RESET_PROGRAM_CNT == 0 || RESET_ERASE_CNT == 0)
  begin : g_check
    $error("operation counts must lie between one and their maximum");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_RESET_WAIT, ST_STOP_WAIT} state_type;

  // ------------------------------------------------------------
  // pin synchronisers and edge detect
  // ------------------------------------------------------------
  logic cs_meta, cs_sync, cs_prev, sck_meta, sck_sync, sck_prev;
  logic cs_rise, sck_rise;
  logic [2:0] bit_count, next_bit_count;

  // two flops before anything looks at a pin
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      {cs_meta, cs_sync, cs_prev}    <= 3'h7;
      {sck_meta, sck_sync, sck_prev} <= 3'h0;
    end else begin
      {cs_meta, cs_sync, cs_prev}    <= {cs_n_in, cs_meta, cs_sync};
      {sck_meta, sck_sync, sck_prev} <= {sck_in, sck_meta, sck_sync};
    end
  end

  assign cs_rise  = cs_sync && !cs_prev;
  assign sck_rise = sck_sync && !sck_prev && !cs_sync;

  // bit count mod 8; a torn byte cancels a pending register write
  always_comb begin
    next_bit_count = bit_count;
    if (cs_sync) begin
      next_bit_count = BIT_COUNT_RESET;
    end else if (sck_rise) begin
      next_bit_count = bit_count + 3'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      bit_count <= BIT_COUNT_RESET;
    end else begin
      bit_count <= next_bit_count;
    end
  end

  // ------------------------------------------------------------
  // bad-block flag memory
  // ------------------------------------------------------------
  logic mem_we, mem_wdata, mark_rd, cur_bad;
  op_req_type cur, next_cur;

  bad_flag_mem #(
    .DEPTH (TOTAL_BLOCKS),
    .WIDTH (1)
  ) u_flags (
    .clk_in        (clk_in),
    .wr_en_in      (mem_we),
    .wr_addr_in    (cur.block),
    .wr_data_in    (mem_wdata),
    .rd_a_addr_in  (marker_block_in),
    .rd_a_data_out (mark_rd),
    .rd_b_addr_in  (cur.block),
    .rd_b_data_out (cur_bad)
  );

  // ------------------------------------------------------------
  // operation sequencer
  // ------------------------------------------------------------
  state_type        state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic             reset_pend, next_reset_pend, wr_pend, next_wr_pend;
  logic [7:0]       wr_data, next_wr_data, next_config;
  logic [BLOCK_W:0] bad_count, next_bad_count;
  status_type       next_status;
  logic             next_done, marker_pend, next_marker_pend;
  logic [BLOCK_W-1:0] marker_blk, next_marker_blk;
  logic [7:0]       next_marker;

  always_comb begin
    next_state      = state;
    next_cnt        = cnt - CNT_W'(1);
    next_cur        = cur;
    next_reset_pend = reset_pend || reset_cmd_in;                // set wins over clear below
    next_wr_pend    = wr_pend || reg_write_in;
    next_wr_data    = reg_write_in ? reg_data_in : wr_data;
    next_config     = config_out;
    next_bad_count  = bad_count;
    next_status     = status_out;
    next_done       = 1'b0;
    mem_we          = 1'b0;
    mem_wdata       = 1'b0;
    // a register write lands on the select release, whole bytes only
    if (cs_rise && wr_pend) begin
      if (bit_count == BIT_COUNT_RESET) begin
        next_config = wr_data;
      end
      // a write strobed in the release cycle stays pending
      next_wr_pend = reg_write_in;
    end
    case (state)
      ST_IDLE: begin
        next_cnt = cnt;
        if (cs_rise && reset_pend) begin
          next_state = ST_RESET_WAIT;
          next_cnt   = RESET_READ_CNT;
        end else if (cs_rise && cont_read_in) begin
          next_state = ST_STOP_WAIT;
          next_cnt   = STOP_CNT;
        end else if (op_start_in && op_req_in.code != OP_NONE) begin
          next_state = ST_BUSY;
          next_cur   = op_req_in;
          next_status.program_fail = 1'b0;
          next_status.erase_fail   = 1'b0;
          case (op_req_in.code)
            OP_PAGE_LOAD: next_cnt = op_req_in.ecc_on ? PAGE_LOAD_CORR_CNT
                                                      : LOAD_CNT;
            OP_ERASE:     next_cnt = ERASE_CNT;
            default:      next_cnt = PROGRAM_CNT;
          endcase
        end
      end
      ST_BUSY: begin
        if (cs_rise && reset_pend) begin
          // abort: recovery depends on what was running
          next_state = ST_RESET_WAIT;
          case (cur.code)
            OP_ERASE:     next_cnt = RESET_ERASE_CNT;
            OP_PAGE_LOAD: next_cnt = RESET_READ_CNT;
            default:      next_cnt = RESET_PROGRAM_CNT;
          endcase
        end else if (cnt == CNT_W'(1)) begin
          next_state = ST_IDLE;
          next_done  = 1'b1;
          case (cur.code)
            OP_PROGRAM, OP_OTP_LOCK: next_status.program_fail = cur_bad;
            OP_ERASE: begin
              // erasing a bad block wipes its marker for good
              next_status.erase_fail = cur_bad;
              if (cur_bad) begin
                mem_we         = 1'b1;
                next_bad_count = bad_count - (BLOCK_W+1)'(1);
              end
            end
            OP_BAD_BLOCK_MAPPING: begin
              // retiring refused for the guaranteed blocks or past the bad budget
              if (cur.block > LAST_SAFE && !cur_bad && bad_count < MAX_BAD) begin
                mem_we         = 1'b1;
                mem_wdata      = 1'b1;
                next_bad_count = bad_count + (BLOCK_W+1)'(1);
              end else if (!cur_bad) begin
                next_status.program_fail = 1'b1;
              end
            end
            default: next_cur = cur;
          endcase
        end
      end
      default: begin
        // reset and stop waits just run down the counter
        if (cnt == CNT_W'(1)) begin
          next_state = ST_IDLE;
          next_done  = 1'b1;
        end
      end
    endcase
    if (cs_rise && reset_pend) begin
      next_reset_pend = reset_cmd_in;
    end
    next_status.busy = (next_state != ST_IDLE);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state            <= ST_IDLE;
      cnt              <= '0;
      cur              <= '0;
      reset_pend       <= 1'b0;
      wr_pend          <= 1'b0;
      wr_data          <= CONFIG_RESET;
      config_out       <= CONFIG_RESET;
      bad_count        <= '0;
      status_out       <= '0;
      op_done_out      <= 1'b0;
      valid_blocks_out <= ALL_BLOCKS;
    end else begin
      state            <= next_state;
      cnt              <= next_cnt;
      cur              <= next_cur;
      reset_pend       <= next_reset_pend;
      wr_pend          <= next_wr_pend;
      wr_data          <= next_wr_data;
      config_out       <= next_config;
      bad_count        <= next_bad_count;
      status_out       <= next_status;
      op_done_out      <= next_done;
      valid_blocks_out <= ALL_BLOCKS - next_bad_count;
    end
  end

  // ------------------------------------------------------------
  // marker lookup: two cycles, memory read then byte
  // ------------------------------------------------------------
  always_comb begin
    next_marker_pend = marker_req_in;
    next_marker_blk  = marker_block_in;
    next_marker      = marker_out;
    if (marker_pend) begin
      next_marker = (mark_rd && marker_blk > LAST_SAFE) ? MARKER_BAD
                                                        : MARKER_GOOD;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      marker_pend      <= 1'b0;
      marker_blk       <= '0;
      marker_out       <= MARKER_GOOD;
      marker_valid_out <= 1'b0;
    end else begin
      marker_pend      <= next_marker_pend;
      marker_blk       <= next_marker_blk;
      marker_out       <= next_marker;
      marker_valid_out <= marker_pend;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic [CNT_W-1:0] busy_len;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !status_out.busy) begin
      busy_len <= '0;
    end else begin
      busy_len <= busy_len + CNT_W'(1);
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  load_plain_a: assert property (state == ST_IDLE && op_start_in && !(cs_rise && (reset_pend
      || cont_read_in)) && op_req_in.code == OP_PAGE_LOAD && !op_req_in.ecc_on
      |=> cnt == LOAD_CNT) else $error("plain page load time wrong");
  load_corr_a: assert property (state == ST_IDLE && op_start_in && !(cs_rise && (reset_pend
      || cont_read_in)) && op_req_in.code == OP_PAGE_LOAD && op_req_in.ecc_on
      |=> cnt == PAGE_LOAD_CORR_CNT) else $error("corrected page load time wrong");
  stop_ready_a: assert property (state == ST_IDLE && cs_rise && !reset_pend && cont_read_in
      |=> state == ST_STOP_WAIT && status_out.busy) else $error("stop not entered");
  // busy_len starts at stop entry, since idle never shows busy
  stop_bound_a: assert property (state == ST_STOP_WAIT
      |-> busy_len < CNT_W'(CONT_READ_STOP_CYCLES)) else $error("stop wait too long");
  busy_bound_a: assert property (busy_len <= CNT_W'(ERASE_MAX_CYCLES))
      else $error("busy outlasted longest operation");
  reset_wait_a: assert property (state == ST_BUSY && cur.code == OP_ERASE && cs_rise
      && reset_pend |=> state == ST_RESET_WAIT && cnt == RESET_ERASE_CNT)
      else $error("erase reset recovery wrong");
  reg_write_a: assert property (cs_rise && wr_pend && bit_count == BIT_COUNT_RESET
      |=> config_out == $past(wr_data)) else $error("register write late");
  safe_block_a: assert property (marker_pend && marker_blk <= LAST_SAFE
      |=> marker_out == MARKER_GOOD) else $error("guaranteed block reported bad");
  bad_budget_a: assert property (bad_count <= MAX_BAD
      && valid_blocks_out == ALL_BLOCKS - bad_count) else $error("bad budget broken");
  marker_bad_a: assert property (marker_pend && mark_rd && marker_blk > LAST_SAFE
      |=> marker_out == MARKER_BAD && marker_valid_out) else $error("bad marker lost");
  busy_flag_a: assert property ($rose(op_done_out) |-> !status_out.busy && $past(status_out.busy))
      else $error("done without busy drop");

  load_seen_c:  cover property (op_done_out && cur.code == OP_PAGE_LOAD);
  erase_bad_c:  cover property (op_done_out && status_out.erase_fail);
  reset_seen_c: cover property (state == ST_RESET_WAIT ##1 state == ST_IDLE);
  map_seen_c:   cover property (mem_we && mem_wdata);
endmodule : nand_op_sequencer

// ==== inc/nand_seq_pkg.sv ====
// shared constants and types for the nand operation sequencer
package nand_seq_pkg;
  // ------------------------------------------------------------
  // clock and operation times
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS               = 10;
  localparam int PAGE_LOAD_NO_CORR_NS        = 25000;     // page_load_time_no_correction
  localparam int PAGE_LOAD_CORR_NS           = 60000;     // page_load_time_with_correction
  localparam int CONT_READ_STOP_NS           = 7000;      // continuous_read_stop_time
  localparam int PAGE_PROGRAM_TYP_NS         = 250000;    // page_program_time, typical
  localparam int PAGE_PROGRAM_MAX_NS         = 700000;    // page_program_time, maximum
  localparam int ERASE_TYP_NS                = 2000000;
  localparam int ERASE_MAX_NS                = 10000000;
  localparam int RESET_READ_NS               = 5000;
  localparam int RESET_PROGRAM_NS            = 10000;
  localparam int RESET_ERASE_NS              = 500000;
  localparam int REGISTER_WRITE_NS           = 50;        // register_write_time
  // all times round down to whole cycles
  localparam int PAGE_LOAD_NO_CORR_CYCLES    = PAGE_LOAD_NO_CORR_NS / CLK_PERIOD_NS;
  localparam int PAGE_LOAD_CORR_CYCLES       = PAGE_LOAD_CORR_NS / CLK_PERIOD_NS;
  localparam int CONT_READ_STOP_CYCLES       = CONT_READ_STOP_NS / CLK_PERIOD_NS;
  localparam int PAGE_PROGRAM_TYP_CYCLES     = PAGE_PROGRAM_TYP_NS / CLK_PERIOD_NS;
  localparam int PAGE_PROGRAM_MAX_CYCLES     = PAGE_PROGRAM_MAX_NS / CLK_PERIOD_NS;
  localparam int ERASE_TYP_CYCLES            = ERASE_TYP_NS / CLK_PERIOD_NS;
  localparam int ERASE_MAX_CYCLES            = ERASE_MAX_NS / CLK_PERIOD_NS;
  localparam int RESET_READ_CYCLES           = RESET_READ_NS / CLK_PERIOD_NS;
  localparam int RESET_PROGRAM_CYCLES        = RESET_PROGRAM_NS / CLK_PERIOD_NS;
  localparam int RESET_ERASE_CYCLES          = RESET_ERASE_NS / CLK_PERIOD_NS;
  localparam int REGISTER_WRITE_CYCLES       = REGISTER_WRITE_NS / CLK_PERIOD_NS;
  // ------------------------------------------------------------
  // array geometry and markers
  // ------------------------------------------------------------
  localparam int CNT_W                       = 24;
  localparam int BLOCK_W                     = 10;
  localparam int TOTAL_BLOCKS                = 1024;
  localparam int MIN_VALID_BLOCKS            = 1004;
  localparam int MAX_BAD_BLOCKS              = TOTAL_BLOCKS - MIN_VALID_BLOCKS;
  localparam int GUARANTEED_LAST_BLOCK       = 7;
  localparam int PARTIAL_PROGRAM_LIMIT       = 4;         // partial_program_limit
  localparam int ECC_BYTES_PER_BIT           = 528;
  localparam logic [7:0] MARKER_GOOD         = 8'hFF;
  localparam logic [7:0] MARKER_BAD          = 8'h00;
  localparam logic [7:0] CONFIG_RESET        = 8'h00;
  localparam logic [2:0] BIT_COUNT_RESET     = 3'h0;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_PAGE_LOAD,
    OP_PROGRAM,
    OP_ERASE,
    OP_BAD_BLOCK_MAPPING,
    OP_OTP_LOCK
  } op_code_type;

  typedef struct packed {
    op_code_type        code;
    logic [BLOCK_W-1:0] block;
    logic               ecc_on;
  } op_req_type;

  typedef struct packed {
    logic program_fail;
    logic erase_fail;
    logic busy;
  } status_type;
endpackage : nand_seq_pkg

// ==== design/bad_flag_mem.sv ====
// bad-block flag memory, one write port and two registered read ports
`timescale 1ns/1ns
module bad_flag_mem
  import nand_seq_pkg::*;
#(
  parameter int DEPTH = TOTAL_BLOCKS,
  parameter int WIDTH = 1
) (
  // clock
  input  wire logic                     clk_in,
  // write port
  input  wire logic                     wr_en_in,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr_in,
  input  wire logic [WIDTH-1:0]         wr_data_in,
  // read ports
  input  wire logic [$clog2(DEPTH)-1:0] rd_a_addr_in,
  output logic      [WIDTH-1:0]         rd_a_data_out,
  input  wire logic [$clog2(DEPTH)-1:0] rd_b_addr_in,
  output logic      [WIDTH-1:0]         rd_b_data_out
);
  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH < 2 || WIDTH < 1) begin : g_check
    $error("bad_flag_mem needs at least two entries");
  end

  // array starts all good, as shipped erased; no reset on ram cells
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      mem[i] = '0;
    end
  end

  // write and registered reads
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_a_data_out <= mem[rd_a_addr_in];
    rd_b_data_out <= mem[rd_b_addr_in];
  end
endmodule : bad_flag_mem

// ==== testbench/host_link_model.sv ====
// host side link model: chip-select frames with a slow serial clock
`timescale 1ns/1ns
module host_link_model (
  // serial link pins
  output logic cs_n_out,
  output logic sck_out
);
  // ----------------------------------------
  // idle levels
  // ----------------------------------------
  // select is pulled up; the link clock stands still between frames
  initial begin
    cs_n_out = 1'b1;
    sck_out  = 1'b0;
  end

  // ----------------------------------------
  // framed transfer
  // ----------------------------------------
  // one frame of so many clock rises, 125 ns period, unrelated to the core clock
  task automatic frame(input int edges);
    // step off the core clock edge so no pin moves as it is sampled
    #2;
    cs_n_out = 1'b0;
    #40;
    repeat (edges) begin
      sck_out = 1'b1;
      #62;
      sck_out = 1'b0;
      #63;
    end
    #40;
    cs_n_out = 1'b1; // caller then waits on done before the next array op
  endtask : frame
endmodule : host_link_model

// ==== testbench/test_nand_op_sequencer.sv ====
// self-checking bench for the nand operation sequencer
`timescale 1ns/1ns
module test_nand_op_sequencer;
  import nand_seq_pkg::*;
  // ----------------------------------------
  // shortened counts and run limit
  // ----------------------------------------
  localparam logic [CNT_W-1:0] LOAD_CNT  = 24'h00003C;
  localparam logic [CNT_W-1:0] PROG_CNT  = 24'h000032;
  localparam logic [CNT_W-1:0] ERASE_CNT = 24'h0000C8;   // outlasts a reset frame
  localparam logic [CNT_W-1:0] RST_E_CNT = 24'h000028;
  localparam int               CEILING   = 20000;

  logic               clk_in, rst_n_in, cs_n, sck, op_start, reset_cmd, cont_read;
  logic               reg_write, marker_req, marker_valid, op_done;
  op_req_type         op_req;
  logic [7:0]         reg_data, marker, config_val;
  logic [BLOCK_W-1:0] marker_block;
  logic [BLOCK_W:0]   valid_blocks;
  status_type         status;
  int                 fails, check_count, cycles, n;

  nand_op_sequencer #(
    .PAGE_LOAD_CORR_CNT(LOAD_CNT), .PROGRAM_CNT(PROG_CNT),
    .ERASE_CNT(ERASE_CNT), .RESET_ERASE_CNT(RST_E_CNT)
  ) nand_op_sequencer_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n), .sck_in(sck),
    .op_start_in(op_start), .op_req_in(op_req), .reset_cmd_in(reset_cmd),
    .cont_read_in(cont_read), .reg_write_in(reg_write), .reg_data_in(reg_data),
    .marker_req_in(marker_req), .marker_block_in(marker_block), .marker_out(marker),
    .marker_valid_out(marker_valid), .status_out(status), .op_done_out(op_done),
    .config_out(config_val), .valid_blocks_out(valid_blocks)
  );
  host_link_model host_link_model_inst (.cs_n_out(cs_n), .sck_out(sck));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  // bounded wait on the done pulse; a hang is also cut by the cycle ceiling
  task automatic wait_done(output int k);
    k = 0;
    while (op_done !== 1'b1 && k < 3000) begin
      @(posedge clk_in);
      #1;
      k++;
    end
  endtask : wait_done

  // start one op, check busy, time to done and both fail flags
  task automatic run_op(input op_code_type code, input int blk, input logic ecc,
                        input int limit, input logic pf, input logic ef);
    int k;
    @(posedge clk_in);
    op_start <= 1'b1;
    op_req   <= '{code: code, block: blk[BLOCK_W-1:0], ecc_on: ecc};
    @(posedge clk_in);
    op_start <= 1'b0;
    @(posedge clk_in);
    #1;
    check("busy after start", 32'h1, status.busy);
    wait_done(k);
    check("op time in limit", 32'h1, k <= limit);
    check("busy at done", 32'h0, status.busy);
    check("program fail", pf, status.program_fail);
    check("erase fail", ef, status.erase_fail);
  endtask : run_op

  // lookup answers one edge after it is taken
  task automatic check_marker(input int blk, input logic [7:0] exp);
    @(posedge clk_in);
    marker_req   <= 1'b1;
    marker_block <= blk[BLOCK_W-1:0];
    @(posedge clk_in);
    marker_req <= 1'b0;
    @(posedge clk_in);
    #1;
    check("marker valid", 32'h1, marker_valid);
    check("marker byte", exp, marker);
  endtask : check_marker

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_loads();
    run_op(OP_PAGE_LOAD, 10, 1'b0, 2500, 1'b0, 1'b0);
    run_op(OP_PAGE_LOAD, 11, 1'b1, LOAD_CNT, 1'b0, 1'b0);
    $display("test page loads done");
  endtask : t_loads

  // program, lock and mapping, then failures and erase of a marked block
  task automatic t_blocks();
    run_op(OP_PROGRAM, 100, 1'b0, PROG_CNT, 1'b0, 1'b0);
    run_op(OP_OTP_LOCK, 101, 1'b0, PROG_CNT, 1'b0, 1'b0);
    check_marker(7, 8'hFF);
    run_op(OP_BAD_BLOCK_MAPPING, 100, 1'b0, PROG_CNT, 1'b0, 1'b0);
    check_marker(100, 8'h00);
    check("valid count", 32'h3FF, valid_blocks);
    run_op(OP_BAD_BLOCK_MAPPING, 3, 1'b0, PROG_CNT, 1'b1, 1'b0);
    check_marker(3, 8'hFF);
    run_op(OP_PROGRAM, 100, 1'b0, PROG_CNT, 1'b1, 1'b0);
    run_op(OP_PROGRAM, 102, 1'b0, PROG_CNT, 1'b0, 1'b0);
    run_op(OP_ERASE, 100, 1'b0, ERASE_CNT, 1'b0, 1'b1);
    check_marker(100, 8'hFF);
    $display("test block handling done");
  endtask : t_blocks

  // whole-byte frame takes the write; a ragged frame drops it
  task automatic t_config(input logic [7:0] data, input int edges, input logic [7:0] exp);
    @(posedge clk_in);
    reg_write <= 1'b1;
    reg_data  <= data;
    @(posedge clk_in);
    reg_write <= 1'b0;
    host_link_model_inst.frame(edges);
    repeat (5) @(posedge clk_in);
    #1;
    check("config value", exp, config_val);
    $display("test register write done");
  endtask : t_config

  task automatic t_stop();
    @(posedge clk_in);
    cont_read <= 1'b1;
    host_link_model_inst.frame(16);
    wait_done(n);
    check("stop time in limit", 32'h1, n <= 705);
    cont_read <= 1'b0;
    $display("test continuous read stop done");
  endtask : t_stop

  // reset lands in mid-erase: abort, recover, no fail, marker kept
  task automatic t_reset_erase();
    run_op(OP_BAD_BLOCK_MAPPING, 200, 1'b0, PROG_CNT, 1'b0, 1'b0);
    check_marker(200, 8'h00);
    @(posedge clk_in);
    op_start <= 1'b1;
    op_req   <= '{code: OP_ERASE, block: 10'h0C8, ecc_on: 1'b0};
    @(posedge clk_in);
    op_start <= 1'b0;
    repeat (5) @(posedge clk_in);
    reset_cmd <= 1'b1;
    @(posedge clk_in);
    reset_cmd <= 1'b0;
    host_link_model_inst.frame(8);
    wait_done(n);
    check("reset wait in limit", 32'h1, n <= RST_E_CNT + 5);
    check("erase fail", 32'h0, status.erase_fail);
    check_marker(200, 8'h00);
    $display("test reset in erase done");
  endtask : t_reset_erase

  // ----------------------------------------
  // clock, limit and main sequence
  // ----------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // cut a hang short long after the expected run of a few thousand cycles
  initial begin
    cycles = 0;
    forever begin
      @(posedge clk_in);
      cycles++;
      if (cycles == CEILING) begin
        fails++;
        $display("[FAIL] run length expected below %0d seen %0d", CEILING, cycles);
        conclude();
      end
    end
  end

  initial begin
    fails        = 0;
    check_count  = 0;
    rst_n_in     = 1'b0;
    op_start     = 1'b0;
    op_req       = '{code: OP_NONE, block: '0, ecc_on: 1'b0};
    reset_cmd    = 1'b0;
    cont_read    = 1'b0;
    reg_write    = 1'b0;
    reg_data     = 8'h00;
    marker_req   = 1'b0;
    marker_block = '0;
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    check("busy after reset", 32'h0, status.busy);
    check("config after reset", 32'h0, config_val);
    check("valid count after reset", 32'h400, valid_blocks);
    t_loads();
    t_blocks();
    t_config(8'hA5, 8, 8'hA5);
    t_config(8'h3C, 7, 8'hA5);
    t_stop();
    t_reset_erase();
    conclude();
  end
endmodule : test_nand_op_sequencer
